// >>> logic/ciem_top.sv
// Interrupt enable mask, line select and line enable registers.
// Assumes status flags arrive synchronous to clk_sys as levels.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

// What this block does
// - A flag reaches an interrupt output only while its enable bit is set.
// - Enable bits: 0 disabled, 1 enabled; all reset to 0.
// - Bit 29 gates the reserved address access interrupt.
// - Bit 28 gates data phase, bit 27 arbitration phase protocol errors.
// - Bit 26 gates the message RAM watchdog interrupt.
// - Bits 25, 24, 23 gate bus off, error warning, error passive.
// - Bit 22 gates the error log counter overflow interrupt.
// - Bit 21 gates uncorrected, bit 20 corrected memory bit errors.
// - Bit 19 gates message stored to a dedicated Rx buffer.
// - Bit 18 gates the timeout elapsed interrupt.
// - Bit 17 gates the message RAM access failure interrupt.
// - Bit 16 gates the timestamp counter wrap interrupt.
// - Bit 15 gates Tx event queue lost, bit 14 its full.
// - Bit 13 gates Tx event queue watermark, bit 12 its new entry.
// - Bit 11 gates the transmit queue empty interrupt.
// - Bit 10 gates cancellation finished, bit 9 transmission complete.
// - Bit 8 gates the high priority message received interrupt.
// - Bits 7 to 4: Rx queue 1 lost, full, watermark, new.
// - Bits 3 to 0: Rx queue 0 lost, full, watermark, new.
// - A per-flag select bit steers it: 0 to line A, 1 to B.
// - A line asserts only while its own line enable bit is set.
module ciem_top #(
    parameter int ADDR_W = ciem_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status flags from the interrupt flag register
    input wire ciem_pkg::ciem_flags_t flags,
    // Module interrupt lines
    output logic irq_line_a,
    output logic irq_line_b
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte strobes widened to a bit mask
    function automatic logic [31:0] strobe_bits(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Word offset of an address, low two bits dropped
    function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        o[1:0] = 2'h0;
        return o;
    endfunction

    // True for any mapped register
    function automatic logic is_mapped(input logic [7:0] o);
        return (o == ciem_pkg::OFS_MASK) || (o == ciem_pkg::OFS_SEL) ||
            (o == ciem_pkg::OFS_LINE_EN) || (o == ciem_pkg::OFS_PENDING);
    endfunction

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] mask;
    logic [31:0] sel;
    logic [31:0] line_en;
    logic [31:0] src;
    logic [31:0] pending;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_ofs;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [31:0] wbits;
    logic [31:0] next_rdata;

    // Flag fields placed on their enable bit positions
    assign src[31] = 1'b0;
    assign src[30] = 1'b0;
    assign src[29] = flags.reserved_addr_access;
    assign src[28] = flags.data_phase_proto_err;
    assign src[27] = flags.arbitration_proto_err;
    assign src[26] = flags.msg_ram_watchdog;
    assign src[25] = flags.bus_off;
    assign src[24] = flags.error_warning;
    assign src[23] = flags.error_passive;
    assign src[22] = flags.error_log_overflow;
    assign src[21] = flags.uncorrected_bit_err;
    assign src[20] = flags.corrected_bit_err;
    assign src[19] = flags.dedicated_rx_stored;
    assign src[18] = flags.timeout;
    assign src[17] = flags.msg_ram_fail;
    assign src[16] = flags.timestamp_wrap;
    assign src[15] = flags.tx_event_lost;
    assign src[14] = flags.tx_event_full;
    assign src[13] = flags.tx_event_watermark;
    assign src[12] = flags.tx_event_new;
    assign src[11] = flags.tx_queue_empty;
    assign src[10] = flags.tx_cancel_done;
    assign src[9] = flags.tx_complete;
    assign src[8] = flags.high_prio_msg;
    assign src[7] = flags.rx_queue1_lost;
    assign src[6] = flags.rx_queue1_full;
    assign src[5] = flags.rx_queue1_watermark;
    assign src[4] = flags.rx_queue1_new;
    assign src[3] = flags.rx_queue0_lost;
    assign src[2] = flags.rx_queue0_full;
    assign src[1] = flags.rx_queue0_watermark;
    assign src[0] = flags.rx_queue0_new;

    // Masked flags; disabled flags still change but go nowhere
    assign pending = src & mask;

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Each half held until both are in and the write is done
    // A second write waits for the response, so one at a time
    assign do_write = aw_got && w_got && !s_axi_bvalid;
    assign wbits = strobe_bits(w_strb);

    // Address capture; ready drops while a write is in flight
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            aw_got <= 1'b0;
            aw_ofs <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_got <= 1'b1;
            aw_ofs <= word_ofs(s_axi_awaddr);
        end else if (do_write) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Data capture, independent of the address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_wready <= 1'b0;
            w_got <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_got <= 1'b0;
        end else if (!w_got && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response; unmapped or read-only targets answer SLVERR
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ciem_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (is_mapped(aw_ofs) && aw_ofs != ciem_pkg::OFS_PENDING) begin
                s_axi_bresp <= ciem_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= ciem_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Enable mask; reserved top bits never store
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask <= ciem_pkg::MASK_RST;
        end else if (do_write && aw_ofs == ciem_pkg::OFS_MASK) begin
            mask <= ((mask & ~wbits) | (w_data & wbits))
                & ciem_pkg::SRC_BITS;
        end
    end

    // Line select, same layout as the mask
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel <= ciem_pkg::SEL_RST;
        end else if (do_write && aw_ofs == ciem_pkg::OFS_SEL) begin
            sel <= ((sel & ~wbits) | (w_data & wbits))
                & ciem_pkg::SRC_BITS;
        end
    end

    // Per-line enables in the two low bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_en <= ciem_pkg::LINE_EN_RST;
        end else if (do_write && aw_ofs == ciem_pkg::OFS_LINE_EN) begin
            line_en <= ((line_en & ~wbits) | (w_data & wbits))
                & ciem_pkg::LINE_EN_BITS;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // Read mux; pending shows live masked flags
    always_comb begin
        next_rdata = 32'h00000000;
        case (word_ofs(s_axi_araddr))
            ciem_pkg::OFS_MASK: next_rdata = mask;
            ciem_pkg::OFS_SEL: next_rdata = sel;
            ciem_pkg::OFS_LINE_EN: next_rdata = line_en;
            ciem_pkg::OFS_PENDING: next_rdata = pending;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // One read at a time, data one cycle after the address
    // Unmapped reads answer zero data with an error code
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= ciem_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            if (is_mapped(word_ofs(s_axi_araddr))) begin
                s_axi_rresp <= ciem_pkg::RESP_OKAY;
            end else begin
                s_axi_rresp <= ciem_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt lines
    // ------------------------------------------------------------
    // Registered so outputs are glitch free; costs one clock
    // Gating after the flop would save the clock but could glitch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_line_a <= 1'b0;
            irq_line_b <= 1'b0;
        end else begin
            irq_line_a <= (|(pending & ~sel))
                && line_en[ciem_pkg::LINE_A_BIT];
            irq_line_b <= (|(pending & sel))
                && line_en[ciem_pkg::LINE_B_BIT];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Line checks look one clock ahead, matching the output flops
    a_reset_clear: assert property (@(posedge clk_sys)
        rst_n && !$past(rst_n) |-> mask == ciem_pkg::MASK_RST && !irq_line_a)
        else $error("mask not clear after reset");

    a_reserved_zero: assert property (@(posedge clk_sys)
        disable iff (!rst_n) mask[31:30] == 2'h0 && sel[31:30] == 2'h0)
        else $error("reserved mask bits set");

    a_no_enable_quiet: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (src & mask) == 32'h00000000 |=>
        !irq_line_a && !irq_line_b)
        else $error("interrupt without enabled flag");

    a_line_gate_b: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !line_en[1] ##1 !line_en[1] |->
        !irq_line_b)
        else $error("line b asserted while disabled");

    a_line_gate_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !line_en[0] |=>
        !irq_line_a)
        else $error("line a asserted while disabled");

    a_steer_to_a: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (src & mask & sel) == 32'h00000000 |=>
        !irq_line_b)
        else $error("line b raised by flag steered to a");

    a_steer_to_b: assert property (@(posedge clk_sys)
        disable iff (!rst_n) (src & mask & ~sel) == 32'h00000000 |=>
        !irq_line_a)
        else $error("line a raised by flag steered to b");

    a_mask_write: assert property (@(posedge clk_sys)
        disable iff (!rst_n) do_write && aw_ofs == ciem_pkg::OFS_MASK &&
        w_strb == 4'hF |=> mask == ($past(w_data) & ciem_pkg::SRC_BITS))
        else $error("mask write not stored");

    a_mask_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_n) !(do_write && aw_ofs == ciem_pkg::OFS_MASK)
        |=> $stable(mask))
        else $error("mask changed without a mask write");

    a_ro_refused: assert property (@(posedge clk_sys)
        disable iff (!rst_n) do_write && aw_ofs == ciem_pkg::OFS_PENDING
        |=> s_axi_bresp == ciem_pkg::RESP_SLVERR)
        else $error("write to pending view not refused");

    a_enable_raises: assert property (@(posedge clk_sys)
        disable iff (!rst_n) $rose(|(src & mask & ~sel)) && $stable(src) &&
        line_en[0] |=> irq_line_a)
        else $error("enabling a set flag did not raise line a");

    a_enable_drops: assert property (@(posedge clk_sys)
        disable iff (!rst_n) $fell(|(src & mask & ~sel)) && $stable(src)
        |=> !irq_line_a)
        else $error("disabling a set flag did not withdraw line a");

    a_read_answer: assert property (@(posedge clk_sys)
        disable iff (!rst_n) s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");

    a_bvalid_hold: assert property (@(posedge clk_sys)
        disable iff (!rst_n) s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    // Each source bit raises line a when enabled, steered to line a (select 0) and on
    for (genvar i = 0; i < ciem_pkg::NUM_SRC; i++) begin : g_src
        a_bit_gate: assert property (@(posedge clk_sys)
            disable iff (!rst_n) src[i] && mask[i] && !sel[i] &&
            line_en[0] |=> irq_line_a)
            else $error("enabled source did not reach line a");
    end

endmodule

// >>> logic/ciem_pkg.sv
// Constants and types for the CAN interrupt enable mask block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package ciem_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MASK = 8'h54;
    localparam logic [7:0] OFS_SEL = 8'h58;
    localparam logic [7:0] OFS_LINE_EN = 8'h5C;
    localparam logic [7:0] OFS_PENDING = 8'h60;

    // ------------------------------------------------------------
    // Reset values and writable fields
    // ------------------------------------------------------------
    localparam logic [31:0] MASK_RST = 32'h00000000;
    localparam logic [31:0] SEL_RST = 32'h00000000;
    localparam logic [31:0] LINE_EN_RST = 32'h00000000;
    localparam logic [31:0] SRC_BITS = 32'h3FFFFFFF;
    localparam logic [31:0] LINE_EN_BITS = 32'h00000003;
    localparam int LINE_A_BIT = 0;
    localparam int LINE_B_BIT = 1;
    localparam int NUM_SRC = 30;

    // ------------------------------------------------------------
    // Bus response codes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Status flags from the controller's flag register, bit 29 first
    typedef struct packed {
        logic reserved_addr_access;
        logic data_phase_proto_err;
        logic arbitration_proto_err;
        logic msg_ram_watchdog;
        logic bus_off;
        logic error_warning;
        logic error_passive;
        logic error_log_overflow;
        logic uncorrected_bit_err;
        logic corrected_bit_err;
        logic dedicated_rx_stored;
        logic timeout;
        logic msg_ram_fail;
        logic timestamp_wrap;
        logic tx_event_lost;
        logic tx_event_full;
        logic tx_event_watermark;
        logic tx_event_new;
        logic tx_queue_empty;
        logic tx_cancel_done;
        logic tx_complete;
        logic high_prio_msg;
        logic rx_queue1_lost;
        logic rx_queue1_full;
        logic rx_queue1_watermark;
        logic rx_queue1_new;
        logic rx_queue0_lost;
        logic rx_queue0_full;
        logic rx_queue0_watermark;
        logic rx_queue0_new;
    } ciem_flags_t;

endpackage

// >>> tb/ciem_flag_src.sv
// Partner model: the controller's interrupt flag register.
// Assumes the bench sets new flag levels through set_flags.
`timescale 1ns/1ps

module ciem_flag_src (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Flag levels towards the mask block
    output ciem_pkg::ciem_flags_t flags
);
    ciem_pkg::ciem_flags_t next_flags = '0;

    // ------------------------------------------------------------
    // Flag register
    // ------------------------------------------------------------
    // Flags move only at an edge, like the real register would
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Staged on the falling edge so it never races the capture edge
    task automatic set_flags(input logic [29:0] v);
        @(negedge clk_sys);
        next_flags = ciem_pkg::ciem_flags_t'(v);
        @(posedge clk_sys);
        #1;
    endtask
endmodule

// >>> tb/can_interrupt_enable_mask_tb_top.sv
// Bench for the interrupt enable mask block over AXI4-Lite.
// Assumes the flag register model and a 25 MHz system clock.
`timescale 1ns/1ps

module can_interrupt_enable_mask_tb_top;
    localparam int LIMIT = 20000;
    logic clk_sys = 1'b0;
    logic rst_n;
    logic [7:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic irq_line_a;
    logic irq_line_b;
    ciem_pkg::ciem_flags_t flags;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    always #20 clk_sys = ~clk_sys;

    ciem_top i_ciem_top (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .flags(flags),
        .irq_line_a(irq_line_a), .irq_line_b(irq_line_b)
    );

    ciem_flag_src i_ciem_flag_src (
        .clk_sys(clk_sys), .rst_n(rst_n), .flags(flags)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Hang guard: a stuck handshake ends the run as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("Error cycles expected below %0d seen %0d", LIMIT, cycles);
            close_out();
        end
    end

    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        cmp("rdata", ed, s_axi_rdata);
        cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    // Output lines are registered: two edges let a change land
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic irq(input logic ea, input logic eb);
        cmp("irq_line_a", {31'h0, ea}, {31'h0, irq_line_a});
        cmp("irq_line_b", {31'h0, eb}, {31'h0, irq_line_b});
    endtask

    // Only bit i enabled: other flags stay silent, its own flag fires
    task automatic check_src(input int i);
        logic [31:0] b;
        b = 32'h1 << i;
        wr(ciem_pkg::OFS_MASK, b, 4'hF, ciem_pkg::RESP_OKAY);
        i_ciem_flag_src.set_flags(~b[29:0]);
        settle();
        irq(1'b0, 1'b0);
        i_ciem_flag_src.set_flags(b[29:0]);
        settle();
        irq(1'b1, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values, all flags up yet no request
        rd(ciem_pkg::OFS_MASK, ciem_pkg::MASK_RST, 2'h0);
        rd(ciem_pkg::OFS_SEL, ciem_pkg::SEL_RST, 2'h0);
        rd(ciem_pkg::OFS_LINE_EN, ciem_pkg::LINE_EN_RST, 2'h0);
        i_ciem_flag_src.set_flags(30'h3FFFFFFF);
        settle();
        irq(1'b0, 1'b0);
        wr(ciem_pkg::OFS_MASK, 32'hFFFFFFFF, 4'hF, 2'h0);
        rd(ciem_pkg::OFS_MASK, ciem_pkg::SRC_BITS, 2'h0);
        $display("Test reset_values done");
        // Each source bit gates its own flag only
        wr(ciem_pkg::OFS_LINE_EN, 32'h1, 4'hF, 2'h0);
        check_src(29);
        check_src(28);
        check_src(27);
        check_src(26);
        check_src(25);
        check_src(24);
        check_src(23);
        check_src(22);
        check_src(21);
        check_src(20);
        check_src(19);
        check_src(18);
        check_src(17);
        check_src(16);
        check_src(15);
        check_src(14);
        check_src(13);
        check_src(12);
        check_src(11);
        check_src(10);
        check_src(9);
        check_src(8);
        for (int k = 4; k < 8; k++) begin
            check_src(k);
        end
        for (int k = 0; k < 4; k++) begin
            check_src(k);
        end
        $display("Test source_bits done");
        // Line steering and line enables
        i_ciem_flag_src.set_flags(30'h00000020);
        wr(ciem_pkg::OFS_MASK, 32'h20, 4'hF, 2'h0);
        wr(ciem_pkg::OFS_SEL, 32'h20, 4'hF, 2'h0);
        wr(ciem_pkg::OFS_LINE_EN, 32'h3, 4'hF, 2'h0);
        settle();
        irq(1'b0, 1'b1);
        wr(ciem_pkg::OFS_LINE_EN, 32'h1, 4'hF, 2'h0);
        settle();
        irq(1'b0, 1'b0);
        wr(ciem_pkg::OFS_SEL, 32'h0, 4'hF, 2'h0);
        settle();
        irq(1'b1, 1'b0);
        wr(ciem_pkg::OFS_LINE_EN, 32'h2, 4'hF, 2'h0);
        settle();
        irq(1'b0, 1'b0);
        $display("Test line_select done");
        // Mask change on a standing flag reaches the line within a clock
        wr(ciem_pkg::OFS_LINE_EN, 32'h1, 4'hF, 2'h0);
        wr(ciem_pkg::OFS_MASK, 32'h0, 4'hF, 2'h0);
        settle();
        irq(1'b0, 1'b0);
        wr(ciem_pkg::OFS_MASK, 32'h20, 4'hF, 2'h0);
        @(posedge clk_sys);
        #1;
        irq(1'b1, 1'b0);
        wr(ciem_pkg::OFS_MASK, 32'h0, 4'hF, 2'h0);
        @(posedge clk_sys);
        #1;
        irq(1'b0, 1'b0);
        $display("Test enable_timing done");
        // Refusals, live pending view and byte lanes
        wr(8'h50, 32'h1, 4'hF, ciem_pkg::RESP_SLVERR);
        rd(8'h50, 32'h0, ciem_pkg::RESP_SLVERR);
        wr(ciem_pkg::OFS_PENDING, 32'h1, 4'hF, ciem_pkg::RESP_SLVERR);
        wr(ciem_pkg::OFS_MASK, 32'hFFFFFFFF, 4'h1, 2'h0);
        rd(ciem_pkg::OFS_MASK, 32'h000000FF, 2'h0);
        rd(ciem_pkg::OFS_PENDING, 32'h00000020, 2'h0);
        $display("Test bus_access done");
        // Reset in mid-run clears the mask again
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(ciem_pkg::OFS_MASK, 32'h0, 2'h0);
        settle();
        irq(1'b0, 1'b0);
        $display("Test second_reset done");
        close_out();
    end
endmodule
